// [rtl/ext_irq_filter_detect.sv]
// What this block does
// - Bits 7 to 5 of the input-four control register read as zero.
// - A read-only bit shows the captured filtered level, zero after reset.
// - That bit is refreshed with the filtered level at every request.
// - Condition 00 rising, 01 falling, 10 both edges of the filtered signal.
// - Condition 11 on input four requests while the filtered signal is high.
// - Full speed samples at gear clock divided by 1, 4, 8 or 16.
// - Low-clock modes sample at the low-frequency clock divided by four.
// - Inputs one to four are programmable; zero and five are fixed.
// - Inputs zero and five filter over two gear periods and detect falling edges.
// - Inputs one to four reject under two intervals, accept over three plus one.
// - Pulses between those bounds on inputs one to four may go either way.
// - In low-clock modes pulses under four periods drop, over eight pass.
// - Full speed needs three agreeing samples on inputs one to four to accept a level.
// - Low-clock modes need two agreeing samples to accept a level.
// - Deep idle, deep sleep and stop halt sampling and requests, save the pulse of an edge found the cycle before.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module ext_irq_filter_detect (
	input  wire logic                             CLOCK,
	input  wire logic                             RESET_N,
	input  wire logic [ext_irq_pkg::ADDR_W-1:0]   ADDRESS,
	input  wire logic                             READ,
	input  wire logic                             WRITE,
	input  wire logic [3:0]                       BYTEENABLE,
	input  wire logic [ext_irq_pkg::DATA_W-1:0]   WRITEDATA,
	output logic      [ext_irq_pkg::DATA_W-1:0]   READDATA,
	output logic                                  WAITREQUEST,
	input  wire logic [ext_irq_pkg::PIN_COUNT-1:0] EXT_IRQ_PIN,
	input  wire logic                             LOW_FREQ_TICK,
	input  wire logic                             LOW_CLOCK_MODE,
	input  wire logic                             SAMPLING_HALT,
	output logic      [ext_irq_pkg::PIN_COUNT-1:0] IRQ_SET
);
	import ext_irq_pkg::*;

	logic                 ack;
	logic                 next_ack;
	logic [DATA_W-1:0]    next_readdata;
	logic [7:0]           read_mux;
	logic [3:0]           divider;
	logic [3:0]           next_divider;
	logic [1:0]           low_divider;
	logic [1:0]           next_low_divider;
	logic                 low_tick;
	logic [PIN_COUNT-1:0] next_irq_set;
	logic [PIN_COUNT-1:0] filtered;
	logic [PIN_COUNT-1:0] change;
	logic [PIN_COUNT-1:0] sample;
	logic [PIN_COUNT-1:0] request;
	ctrl_type             ctrl [1:4];

	// -----------------------------------------------------------------
	// Avalon slave: one wait cycle, then the answer
	// -----------------------------------------------------------------
	// Every access waits exactly one cycle so read data is registered.
	assign WAITREQUEST = (READ || WRITE) && !ack;

	always_comb begin
		read_mux = 8'h00;
		for (int k = 1; k <= 4; k++) begin
			if (ADDRESS[ADDR_W-1:2] == CTRL_INDEX_ONE + 12'(k - 1)) begin
				read_mux = {3'h0, ctrl[k]};
			end
		end
		next_ack = (READ || WRITE) && !ack;
		next_readdata = READDATA;
		if (READ && !ack) begin
			next_readdata = {24'h000000, read_mux};
		end
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			ack <= 1'b0;
			READDATA <= '0;
		end else begin
			ack <= next_ack;
			READDATA <= next_readdata;
		end
	end

	// -----------------------------------------------------------------
	// Sampling rate dividers
	// -----------------------------------------------------------------
	always_comb begin
		next_divider = SAMPLING_HALT ? divider : divider + 4'h1;
		next_low_divider = low_divider;
		if (LOW_FREQ_TICK && !SAMPLING_HALT) begin
			next_low_divider = low_divider + 2'h1;
		end
	end

	// The low-clock divider only moves on low-frequency ticks, so a halt
	// keeps its phase and the first sample after the release is not early.
	assign low_tick = LOW_FREQ_TICK && !SAMPLING_HALT &&
		low_divider == LOW_DIV_LAST;

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			divider <= 4'h0;
			low_divider <= 2'h0;
		end else begin
			divider <= next_divider;
			low_divider <= next_low_divider;
		end
	end

	// -----------------------------------------------------------------
	// Per input filtering and request detection
	// -----------------------------------------------------------------
	// The low-clock filter is shared by every input; the gear-clock
	// path differs between programmable and fixed inputs.
	for (genvar g = 0; g < PIN_COUNT; g++) begin : gen_pin
		localparam bit PROG = (g >= 1) && (g <= 4);
		logic [1:0] agree;
		logic       full_tick;

		if (PROG) begin : gen_prog
			ctrl_type next_ctrl;
			logic     write_hit;
			logic     req;

			always_comb begin
				unique case (ctrl[g].interval)
					2'h0: full_tick = 1'b1;
					2'h1: full_tick = divider[1:0] == 2'h3;
					2'h2: full_tick = divider[2:0] == 3'h7;
					2'h3: full_tick = divider == 4'hf;
				endcase
				unique case (ctrl[g].cond)
					COND_RISE: req = change[g] && filtered[g];
					COND_FALL: req = change[g] && !filtered[g];
					COND_BOTH: req = change[g];
					// Only input four owns the high-level mode.
					COND_HIGH: req = (g == 4) && filtered[g] &&
						!SAMPLING_HALT;
				endcase
				write_hit = WRITE && ack && BYTEENABLE[0] &&
					ADDRESS[ADDR_W-1:2] == CTRL_INDEX_ONE + 12'(g - 1);
				next_ctrl = ctrl[g];
				if (write_hit) begin
					next_ctrl.cond = WRITEDATA[COND_LSB+:2];
					next_ctrl.interval = WRITEDATA[INTERVAL_LSB+:2];
				end
				if (req) begin
					next_ctrl.level = filtered[g];
				end
			end

			always_ff @(posedge CLOCK or negedge RESET_N) begin
				if (!RESET_N) begin
					ctrl[g] <= ctrl_type'(CTRL_RESET[4:0]);
				end else begin
					ctrl[g] <= next_ctrl;
				end
			end
			assign request[g] = req;
			assign agree = FULL_AGREE;
		end else begin : gen_fixed
			assign full_tick = 1'b1;
			assign request[g] = change[g] && !filtered[g];
			assign agree = FIXED_AGREE;
		end

		assign sample[g] = SAMPLING_HALT ? 1'b0 :
			(LOW_CLOCK_MODE ? low_tick : full_tick);

		noise_filter u_filter (
			.clk         (CLOCK),
			.reset_n     (RESET_N),
			.pin         (EXT_IRQ_PIN[g]),
			.sample      (sample[g]),
			.agree_count (LOW_CLOCK_MODE ? LOW_AGREE : agree),
			.level       (filtered[g]),
			.change      (change[g])
		);
	end

	// -----------------------------------------------------------------
	// Request pulses to the interrupt latch
	// -----------------------------------------------------------------
	// Registering the pulse keeps decode glitches away from the interrupt
	// latch, at the cost of one cycle of latency.
	always_comb begin
		next_irq_set = request;
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			IRQ_SET <= '0;
		end else begin
			IRQ_SET <= next_irq_set;
		end
	end

	// -----------------------------------------------------------------
	// Check helpers
	// -----------------------------------------------------------------
	// A sixteen-cycle interval is too long to unroll in a property, so the
	// cycles between two samples of input one are counted here instead.
	logic [4:0] gap_one;
	logic [4:0] next_gap_one;
	logic       slow_armed;
	logic       next_slow_armed;
	logic       slow_one;

	assign slow_one = !SAMPLING_HALT && !LOW_CLOCK_MODE &&
		ctrl[1].interval == 2'h3;

	always_comb begin
		next_gap_one = gap_one;
		if (sample[1]) begin
			next_gap_one = 5'h00;
		end else if (gap_one != 5'h1f) begin
			next_gap_one = gap_one + 5'h01;
		end
		next_slow_armed = slow_armed;
		if (!slow_one) begin
			next_slow_armed = 1'b0;
		end else if (sample[1]) begin
			next_slow_armed = 1'b1;
		end
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			gap_one <= 5'h00;
			slow_armed <= 1'b0;
		end else begin
			gap_one <= next_gap_one;
			slow_armed <= next_slow_armed;
		end
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RESET_N);

	chk_reserved_zero: assert property (
		READ && !WAITREQUEST |-> READDATA[7:5] == 3'h0)
		else $error("reserved control bits read nonzero");
	chk_level_refresh: assert property (
		request[4] |=> ctrl[4].level == $past(filtered[4]))
		else $error("captured level not refreshed on request");
	chk_rise_edge: assert property (
		ctrl[4].cond == COND_RISE && change[4] && filtered[4] |=> IRQ_SET[4])
		else $error("rising edge missed on input four");
	chk_high_level: assert property (
		ctrl[4].cond == COND_HIGH && filtered[4] && !SAMPLING_HALT |=> IRQ_SET[4])
		else $error("high level request missing");
	chk_slow_interval: assert property (
		slow_one && slow_armed && sample[1] |-> gap_one == 5'h0f)
		else $error("divide by sixteen interval wrong");
	chk_low_sampling: assert property (
		LOW_CLOCK_MODE && sample[2] |-> LOW_FREQ_TICK && low_divider == 2'h3)
		else $error("low clock sample off the divide by four tick");
	chk_fixed_fall: assert property (
		IRQ_SET[0] |-> $past(change[0]) && !$past(filtered[0]))
		else $error("fixed input fired on a non-falling edge");
	// An edge found in the cycle before a halt still leaves its pulse.
	chk_halt_quiet: assert property (
		SAMPLING_HALT [*3] |-> IRQ_SET == '0)
		else $error("request raised while sampling is halted");
	chk_pulse_cause: assert property (
		IRQ_SET[3] |-> $past(change[3]))
		else $error("edge request without a level change");
	chk_halt_frozen: assert property (
		SAMPLING_HALT |-> sample == '0)
		else $error("sampling went on while halted");
	chk_read_level: assert property (
		READ && !WAITREQUEST && ADDRESS[ADDR_W-1:2] == CTRL_INDEX_FOUR |->
		READDATA[LEVEL_BIT] == $past(ctrl[4].level))
		else $error("captured level read back wrong");
	chk_full_tick: assert property (
		!SAMPLING_HALT && !LOW_CLOCK_MODE && ctrl[4].interval == 2'h0 |-> sample[4])
		else $error("undivided interval skipped a sample");
	chk_fixed_every: assert property (
		!SAMPLING_HALT && !LOW_CLOCK_MODE |-> sample[0] && sample[5])
		else $error("fixed input skipped a gear sample");
	chk_change_one: assert property (
		IRQ_SET[1] |-> $past(change[1]))
		else $error("input one fired without a level change");

	// -----------------------------------------------------------------
	// Cover points
	// -----------------------------------------------------------------
	cov_both_edges: cover property (ctrl[4].cond == COND_BOTH && IRQ_SET[4]);
	cov_high_repeat: cover property (IRQ_SET[4] [*3]);
	cov_low_request: cover property (LOW_CLOCK_MODE && IRQ_SET[5]);
	cov_slow_interval: cover property (slow_armed && sample[1]);
	cov_halt_release: cover property ($fell(SAMPLING_HALT));

endmodule
`default_nettype wire

// [rtl/ext_irq_pkg.sv]
package ext_irq_pkg;

	// -----------------------------------------------------------------
	// Bus and register map
	// -----------------------------------------------------------------
	localparam int          ADDR_W        = 14;
	localparam int          DATA_W        = 32;
	localparam int          PIN_COUNT     = 6;
	// Word indices; the byte address is four times the index.
	localparam logic [11:0] CTRL_INDEX_ONE  = 12'hfd8;
	localparam logic [11:0] CTRL_INDEX_FOUR = 12'hfdb;
	localparam int          LEVEL_BIT     = 4;
	localparam int          COND_LSB      = 2;
	localparam int          INTERVAL_LSB  = 0;
	localparam logic [7:0]  CTRL_RESET    = 8'h00;

	// -----------------------------------------------------------------
	// Field codes and filter figures
	// -----------------------------------------------------------------
	localparam logic [1:0]  COND_RISE     = 2'h0;
	localparam logic [1:0]  COND_FALL     = 2'h1;
	localparam logic [1:0]  COND_BOTH     = 2'h2;
	localparam logic [1:0]  COND_HIGH     = 2'h3;
	localparam logic [1:0]  FULL_AGREE    = 2'h3;
	localparam logic [1:0]  LOW_AGREE     = 2'h2;
	localparam logic [1:0]  FIXED_AGREE   = 2'h2;
	localparam logic [1:0]  LOW_DIV_LAST  = 2'h3;

	typedef struct packed {
		logic       level;
		logic [1:0] cond;
		logic [1:0] interval;
	} ctrl_type;

endpackage

// [rtl/noise_filter.sv]
`timescale 1ns/10ps
`default_nettype none
module noise_filter (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       pin,
	input  wire logic       sample,
	input  wire logic [1:0] agree_count,
	output logic            level,
	output logic            change
);
	import ext_irq_pkg::*;

	logic       gear_sample;
	logic [2:0] history;
	logic       agree;
	logic       next_gear_sample;
	logic [2:0] next_history;
	logic       next_level;
	logic       next_change;

	// -----------------------------------------------------------------
	// Sample history and level decision
	// -----------------------------------------------------------------
	// The pin is first taken on the gear clock, which adds one gear
	// period to the accept bound for the programmable inputs.
	always_comb begin
		next_gear_sample = pin;
		next_history = history;
		if (sample) begin
			next_history = {history[1:0], gear_sample};
		end
		if (agree_count == FULL_AGREE) begin
			agree = (next_history[0] == next_history[1]) &&
				(next_history[1] == next_history[2]);
		end else begin
			agree = next_history[0] == next_history[1];
		end
		next_level = level;
		next_change = 1'b0;
		if (sample && agree && next_history[0] != level) begin
			next_level = next_history[0];
			next_change = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gear_sample <= 1'b0;
			history <= 3'h0;
			level <= 1'b0;
			change <= 1'b0;
		end else begin
			gear_sample <= next_gear_sample;
			history <= next_history;
			level <= next_level;
			change <= next_change;
		end
	end

endmodule
`default_nettype wire

// [testbench/pin_side_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// Pins and interrupt acceptance
// ---------------------------------------------------------------
module pin_side_model (
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic [5:0]      level,
	input  wire logic [5:0]      set,
	input  wire logic            clear,
	output logic      [5:0]      pin,
	output logic                 tick,
	output logic      [5:0][7:0] hits
);
	logic [2:0] div;
	// Counting rather than latching lets a test see a second, unwanted request.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin <= 6'h21;
			div <= 3'h0;
			tick <= 1'b0;
			hits <= '0;
		end else begin
			pin <= level;
			div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
			tick <= (div == 3'h4);
			for (int i = 0; i < 6; i++) begin
				hits[i] <= clear ? 8'h00 : hits[i] + {7'h00, set[i]};
			end
		end
	end
endmodule
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
	import ext_irq_pkg::*;
	localparam logic [ADDR_W-1:0] R4 = {CTRL_INDEX_FOUR, 2'b00};
	localparam logic [ADDR_W-1:0] R1 = {CTRL_INDEX_ONE, 2'b00};
	logic CLOCK = 0, RESET_N = 0, READ = 0, WRITE = 0, LOW_CLOCK_MODE = 0, SAMPLING_HALT = 0;
	logic clr = 0, tick, WAITREQUEST;
	logic [3:0] BYTEENABLE = 4'hf;
	logic [ADDR_W-1:0] ADDRESS = '0;
	logic [31:0] WRITEDATA = '0, READDATA, q;
	logic [5:0] lv = 6'h21, pin, IRQ_SET;
	logic [5:0][7:0] hits;
	int err_total = 0, compares = 0;
	always #50 CLOCK = ~CLOCK;
	ext_irq_filter_detect i_dut (.CLOCK(CLOCK), .RESET_N(RESET_N), .ADDRESS(ADDRESS),
		.READ(READ), .WRITE(WRITE), .BYTEENABLE(BYTEENABLE), .WRITEDATA(WRITEDATA),
		.READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .EXT_IRQ_PIN(pin),
		.LOW_FREQ_TICK(tick), .LOW_CLOCK_MODE(LOW_CLOCK_MODE),
		.SAMPLING_HALT(SAMPLING_HALT), .IRQ_SET(IRQ_SET));
	pin_side_model i_pins (.clk(CLOCK), .rst_n(RESET_N), .level(lv), .set(IRQ_SET),
		.clear(clr), .pin(pin), .tick(tick), .hits(hits));
	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task report_and_stop;
		$display("counts: %0d compares, %0d mismatches", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		ADDRESS <= a;
		WRITEDATA <= d;
		READ <= !wr;
		WRITE <= wr;
		do begin
			@(posedge CLOCK);
		end while (WAITREQUEST !== 1'b0);
		q = READDATA;
		READ <= 1'b0;
		WRITE <= 1'b0;
	endtask
	task idle(input int n);
		repeat (n) @(posedge CLOCK);
	endtask
	task clear_hits;
		@(posedge CLOCK) clr <= 1'b1;
		@(posedge CLOCK) clr <= 1'b0;
	endtask
	task setup(input logic [7:0] d);
		bus(1'b1, R4, {24'h0, d});
		idle(150);
		clear_hits;
	endtask
	task step(input int p, input logic v, input logic [7:0] exp);
		@(posedge CLOCK) lv[p] <= v;
		idle(150);
		chk({24'h0, hits[p]}, {24'h0, exp});
		clear_hits;
	endtask
	task pulse(input int p, input logic v, input int w, input logic [7:0] exp);
		@(posedge CLOCK) lv[p] <= v;
		idle(w);
		lv[p] <= !v;
		idle(150);
		chk({24'h0, hits[p]}, {24'h0, exp});
		clear_hits;
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task t_regs;
		bus(1'b0, R4, '0); chk(q, 32'h0);
		bus(1'b0, R4 + 14'h4, '0); chk(q, 32'h0);
		setup(8'hff);
		bus(1'b0, R4, '0); chk(q, 32'h0f);
		setup(8'h00);
		bus(1'b1, R1, 32'h03);
		bus(1'b0, R1, '0); chk(q, 32'h03);
		$display("test regs done");
	endtask
	task t_edges;
		step(4, 1, 1);
		bus(1'b0, R4, '0); chk(q, 32'h10);
		step(4, 0, 0);
		setup(8'h04);
		step(4, 1, 0);
		step(4, 0, 1);
		bus(1'b0, R4, '0); chk(q, 32'h04);
		setup(8'h08);
		step(4, 1, 1);
		bus(1'b0, R4, '0); chk(q, 32'h18);
		step(4, 0, 1);
		step(1, 1, 1);
		step(1, 0, 0);
		step(0, 0, 1);
		step(0, 1, 0);
		step(5, 0, 1);
		step(5, 1, 0);
		$display("test edges done");
	endtask
	task t_high;
		int n;
		n = 0;
		setup(8'h0c);
		@(posedge CLOCK) lv[4] <= 1'b1;
		idle(20);
		repeat (10) @(posedge CLOCK) n += int'(IRQ_SET[4] === 1'b1);
		chk(n, 10);
		bus(1'b0, R4, '0); chk(q, 32'h1c);
		lv[4] <= 1'b0;
		idle(30);
		clear_hits;
		idle(40);
		chk({24'h0, hits[4]}, 32'h0);
		$display("test high done");
	endtask
	task t_filter;
		for (int i = 0; i < 4; i++) begin
			setup(i[7:0]);
			pulse(4, 1, 2 * (1 << (i + (i > 0))) - 1, 0);
			pulse(4, 1, 3 * (1 << (i + (i > 0))) + 3, 1);
		end
		$display("test filter done");
	endtask
	task t_low;
		@(posedge CLOCK) LOW_CLOCK_MODE <= 1'b1;
		idle(300);
		clear_hits;
		pulse(4, 1, 15, 0);
		pulse(4, 1, 50, 1);
		pulse(0, 0, 50, 1);
		pulse(5, 0, 50, 1);
		LOW_CLOCK_MODE <= 1'b0;
		idle(100);
		clear_hits;
		$display("test low done");
	endtask
	task t_halt;
		setup(8'h08);
		@(posedge CLOCK) SAMPLING_HALT <= 1'b1;
		lv[4] <= 1'b1;
		idle(100);
		chk({24'h0, hits[4]}, 32'h0);
		SAMPLING_HALT <= 1'b0;
		idle(100);
		chk({24'h0, hits[4]}, 32'h1);
		$display("test halt done");
	endtask
	initial begin
		idle(2);
		RESET_N <= 1'b1;
		idle(20);
		clear_hits;
		t_regs;
		t_edges;
		t_high;
		t_filter;
		t_low;
		t_halt;
		report_and_stop;
	end
	initial begin
		idle(40000);
		err_total++;
		report_and_stop;
	end
endmodule
`default_nettype wire
